/* File: core/serial_port.sv */
/*
  Asynchronous serial transceiver: mode and status/control registers,
  baud sample generator, four-deep transmit and receive queues, framing,
  parity, break, address detect and overrun handling.
  Assumes a register master on sys_clk that never needs wait states, and
  an external pad that turns tx_line_oe low into general-purpose control.
*/
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - receive polarity set means low idle receive line, bits inverted.
// - high-speed baud gives 4 samples per bit, otherwise 16.
// - format 11 nine bits, 10 odd parity, 01 even parity, 00 none.
// - stop-bit select set sends two stop bits, clear sends one.
// - tx interrupt on load, on full completion, or on load emptying queue.
// - tx polarity sets idle level; with infrared coding it sets encoded idle.
// - send-break sends start, twelve zeros, stop, then clears itself.
// - tx enable low aborts, empties the queue and releases the pin.
// - tx full flag set when the queue cannot take another character.
// - tx all-empty flag only when shifter and queue are empty; resets high.
// - rx interrupt at four, three, or every stored character per mode.
// - address detect keeps only ninth-bit-set characters, nine-bit format only.
// - receiver idle flag high while idle, low while receiving; resets high.
// - parity error flag follows the character at the receive queue head.
// - framing error flag follows the character at the receive queue head.
// - overrun sets on overflow; software clear empties queue and shifter.
// - data-available flag high while the receive queue holds a character.
// - transmit data passes a four-deep first-in first-out queue.
module serial_port
  import serial_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_line_oe,
  output logic tx_irq,
  output logic rx_irq
);

  // ---------------------------------------------------------------
  // state and helpers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] stat;
    logic [15:0] baud_div;
    logic [15:0] baud_cnt;
    logic [3:0][8:0] txf;
    logic [1:0] txw;
    logic [1:0] txr;
    logic [2:0] txn;
    tx_state_t txs;
    logic [13:0] tsh;
    logic [3:0] tbits;
    logic [4:0] tsc;
    logic tbrk;
    logic tx_out;
    logic rx_s1;
    logic rx_s2;
    rx_state_t rxs;
    logic [10:0] rsh;
    logic [3:0] rbits;
    logic [4:0] rsc;
    logic [3:0][10:0] rxf;
    logic [1:0] rxw;
    logic [1:0] rxr;
    logic [2:0] rxn;
    logic [15:0] rdata;
    logic tx_irq;
    logic rx_irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic nine_bit(input logic [1:0] f);
    return f == FMT_9N;
  endfunction

  function automatic logic has_parity(input logic [1:0] f);
    return f == FMT_8E || f == FMT_8O;
  endfunction

  // frame bits lsb first with start at bit 0, length in the top nibble
  function automatic logic [17:0] tx_frame(input logic [8:0] d, input logic [1:0] f,
                                           input logic two);
    logic [13:0] v;
    logic [3:0] len;
    v = 14'h3fff;
    v[0] = 1'b0;
    v[8:1] = d[7:0];
    len = 4'h9;
    if (nine_bit(f))
    begin
      v[9] = d[8];
      len = 4'ha;
    end
    else if (has_parity(f))
    begin
      v[9] = (f == FMT_8E) ? ^d[7:0] : ~^d[7:0];
      len = 4'ha;
    end
    len = len + (two ? 4'h2 : 4'h1);
    return {len, v};
  endfunction

  logic tick;
  logic [4:0] spb;
  logic [1:0] fmt;
  logic rxb;
  logic tx_en;
  logic tx_full;
  logic tx_all_empty;
  logic [1:0] tx_mode;
  logic [1:0] rx_mode;
  logic [3:0] rx_need;
  logic [10:0] rx_full;
  logic [10:0] rx_head;
  logic [15:0] stat_word;
  logic [17:0] next_frame;
  logic tx_push;
  logic tx_pop;
  logic tx_done;
  logic rx_done;
  logic rx_keep;
  logic rx_push;
  logic rx_pop;
  logic rx_flush;
  logic ovr_set;
  logic tbit;

  // >= so a smaller divisor written mid-count cannot stall for a full wrap
  assign tick = s_q.baud_cnt >= s_q.baud_div;
  assign spb = s_q.mode[MODE_HIGH_SPEED_BAUD] ? SPB_HIGH : SPB_STD;
  assign fmt = s_q.mode[MODE_FMT +: 2];
  assign rxb = s_q.rx_s2 ^ s_q.mode[MODE_RXINV];
  assign tx_en = s_q.stat[ST_TXEN];
  assign tx_full = s_q.txn == FIFO_DEPTH;
  assign tx_all_empty = s_q.txs == TX_IDLE && s_q.txn == 3'h0;
  assign tx_mode = {s_q.stat[ST_TXIS1], s_q.stat[ST_TXIS0]};
  assign rx_mode = s_q.stat[ST_RXIS +: 2];
  assign rx_need = (fmt == FMT_8N) ? 4'h9 : 4'ha;
  assign rx_full = {rxb, s_q.rsh[10:1]} >> (4'hb - rx_need);
  assign rx_head = s_q.rxf[s_q.rxr];
  assign next_frame = tx_frame(s_q.txf[s_q.txr], fmt, s_q.mode[MODE_STOP_BITS_SEL]);
  assign tbit = (s_q.txs == TX_SHIFT) ? s_q.tsh[0] : 1'b1;

  always_comb
  begin
    stat_word = s_q.stat;
    stat_word[ST_TXBF] = tx_full;
    stat_word[ST_TX_ALL_EMPTY_FLAG] = tx_all_empty;
    stat_word[ST_RX_IDLE_FLAG] = s_q.rxs == RX_IDLE;
    stat_word[ST_PARITY_ERR_FLAG] = s_q.rxn != 3'h0 && rx_head[9];
    stat_word[ST_FRAMING_ERR_FLAG] = s_q.rxn != 3'h0 && rx_head[10];
    stat_word[ST_RXDA] = s_q.rxn != 3'h0;
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.tx_irq = 1'b0;
    s_d.rx_irq = 1'b0;
    s_d.rdata = 16'h0000;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_done = 1'b0;
    rx_done = 1'b0;
    rx_keep = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_flush = 1'b0;
    ovr_set = 1'b0;
    // first flop only feeds the second
    s_d.rx_s1 = rx_line;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.baud_cnt = tick ? 16'h0000 : s_q.baud_cnt + 16'h0001;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        MODE_IDX: s_d.mode = reg_wdata & MODE_WR_MASK;
        STAT_IDX:
        begin
          s_d.stat = (s_q.stat & ~STAT_WR_MASK) | (reg_wdata & STAT_WR_MASK);
          // overrun only clears; the 1 to 0 edge empties the receive path
          if (s_q.stat[ST_OVERRUN_FLAG] && !reg_wdata[ST_OVERRUN_FLAG])
          begin
            s_d.stat[ST_OVERRUN_FLAG] = 1'b0;
            rx_flush = 1'b1;
          end
        end
        TXD_IDX: tx_push = tx_en && !tx_full;
        BAUD_IDX: s_d.baud_div = reg_wdata;
        default: ;
      endcase
    end

    // register reads, data valid the cycle after the strobe
    if (reg_rd)
    begin
      case (reg_addr)
        MODE_IDX: s_d.rdata = s_q.mode;
        STAT_IDX: s_d.rdata = stat_word;
        RXD_IDX:
        begin
          s_d.rdata = {7'h00, rx_head[8:0]};
          rx_pop = s_q.rxn != 3'h0;
        end
        BAUD_IDX: s_d.rdata = s_q.baud_div;
        default: s_d.rdata = 16'h0000;
      endcase
    end

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    if (tx_en)
    begin
      case (s_q.txs)
        TX_IDLE:
        begin
          if (s_q.stat[ST_BRK])
          begin
            s_d.tsh = BREAK_FRAME;
            s_d.tbits = BREAK_LEN;
            s_d.tbrk = 1'b1;
            s_d.tsc = 5'h00;
            s_d.txs = TX_SHIFT;
          end
          else if (s_q.txn != 3'h0)
          begin
            s_d.tsh = next_frame[13:0];
            s_d.tbits = next_frame[17:14];
            s_d.tbrk = 1'b0;
            s_d.tsc = 5'h00;
            s_d.txs = TX_SHIFT;
            tx_pop = 1'b1;
            if (tx_mode == TXI_EACH || (tx_mode == TXI_EMPTY && s_q.txn == 3'h1 && !tx_push))
              s_d.tx_irq = 1'b1;
          end
        end
        TX_SHIFT:
        begin
          if (tick)
          begin
            if (s_q.tsc == spb - 5'h01)
            begin
              s_d.tsc = 5'h00;
              s_d.tsh = {1'b1, s_q.tsh[13:1]};
              s_d.tbits = s_q.tbits - 4'h1;
              if (s_q.tbits == 4'h1)
              begin
                tx_done = 1'b1;
                s_d.txs = TX_IDLE;
                // a software set in the same cycle wins over the hardware clear
                if (s_q.tbrk && !(reg_wr && reg_addr == STAT_IDX && reg_wdata[ST_BRK]))
                  s_d.stat[ST_BRK] = 1'b0;
                if (tx_mode == TXI_DONE && s_q.txn == 3'h0 && !tx_push)
                  s_d.tx_irq = 1'b1;
              end
            end
            else
              s_d.tsc = s_q.tsc + 5'h01;
          end
        end
        default: s_d.txs = TX_IDLE;
      endcase
    end

    if (tx_push)
    begin
      s_d.txf[s_q.txw] = reg_wdata[8:0];
      s_d.txw = s_q.txw + 2'h1;
    end
    if (tx_pop)
      s_d.txr = s_q.txr + 2'h1;
    s_d.txn = s_q.txn + {2'h0, tx_push} - {2'h0, tx_pop};
    if (!tx_en)
    begin
      s_d.txs = TX_IDLE;
      s_d.txw = 2'h0;
      s_d.txr = 2'h0;
      s_d.txn = 3'h0;
    end

    // infrared: a zero bit is a short pulse at the start of its bit time
    if (s_q.mode[MODE_INFRARED_CODING_EN])
      s_d.tx_out = (!tbit && s_q.tsc < IR_PULSE) ? !s_q.stat[ST_TXINV] : s_q.stat[ST_TXINV];
    else
      s_d.tx_out = tbit ^ s_q.stat[ST_TXINV];

    // ---------------------------------------------------------------
    // receiver
    // ---------------------------------------------------------------
    case (s_q.rxs)
      RX_IDLE:
      begin
        if (!rxb)
        begin
          s_d.rxs = RX_START;
          s_d.rsc = 5'h00;
        end
      end
      RX_START:
      begin
        if (tick)
        begin
          s_d.rsc = s_q.rsc + 5'h01;
          // mid-start check rejects glitches shorter than half a bit
          if (s_q.rsc == {1'b0, spb[4:1]})
          begin
            s_d.rsc = 5'h00;
            s_d.rbits = 4'h0;
            s_d.rxs = rxb ? RX_IDLE : RX_BITS;
          end
        end
      end
      RX_BITS:
      begin
        if (tick)
        begin
          if (s_q.rsc == spb - 5'h01)
          begin
            s_d.rsc = 5'h00;
            s_d.rsh = {rxb, s_q.rsh[10:1]};
            s_d.rbits = s_q.rbits + 4'h1;
            if (s_q.rbits + 4'h1 == rx_need)
            begin
              rx_done = 1'b1;
              s_d.rxs = RX_IDLE;
            end
          end
          else
            s_d.rsc = s_q.rsc + 5'h01;
        end
      end
      default: s_d.rxs = RX_IDLE;
    endcase

    if (rx_done)
    begin
      rx_keep = !(s_q.stat[ST_ADDR_DETECT_EN] && nine_bit(fmt) && !rx_full[8]);
      if (rx_keep && s_q.rxn == FIFO_DEPTH)
        ovr_set = 1'b1;
      else if (rx_keep)
      begin
        rx_push = 1'b1;
        s_d.rxf[s_q.rxw][8:0] = nine_bit(fmt) ? rx_full[8:0] : {1'b0, rx_full[7:0]};
        s_d.rxf[s_q.rxw][9] = (fmt == FMT_8E) ? ^rx_full[8:0] :
                              (fmt == FMT_8O) ? ~^rx_full[8:0] : 1'b0;
        s_d.rxf[s_q.rxw][10] = !rxb;
        if (!rx_mode[1] || (rx_mode == RXI_3Q && s_q.rxn == 3'h2)
            || (rx_mode == RXI_FULL && s_q.rxn == 3'h3))
          s_d.rx_irq = 1'b1;
      end
    end
    if (rx_push)
      s_d.rxw = s_q.rxw + 2'h1;
    if (rx_pop)
      s_d.rxr = s_q.rxr + 2'h1;
    s_d.rxn = s_q.rxn + {2'h0, rx_push} - {2'h0, rx_pop};
    if (rx_flush)
    begin
      s_d.rxw = 2'h0;
      s_d.rxr = 2'h0;
      s_d.rxn = 3'h0;
      s_d.rxs = RX_IDLE;
      s_d.rsh = 11'h000;
    end
    // a new overflow in the clearing cycle keeps the flag set
    if (ovr_set)
      s_d.stat[ST_OVERRUN_FLAG] = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.mode <= MODE_RESET;
      s_q.stat <= STAT_RESET;
      s_q.baud_div <= BAUD_RESET;
      s_q.rx_s1 <= 1'b1;
      s_q.rx_s2 <= 1'b1;
      s_q.tx_out <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign tx_line = s_q.tx_out;
  assign tx_line_oe = tx_en;
  assign tx_irq = s_q.tx_irq;
  assign rx_irq = s_q.rx_irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence brk_request;
    tx_en && s_q.txs == TX_IDLE && s_q.stat[ST_BRK];
  endsequence

  sequence brk_loaded;
    s_q.txs == TX_SHIFT && s_q.tsh == BREAK_FRAME && s_q.tbits == BREAK_LEN;
  endsequence

  break_frame_a: assert property (brk_request |=> brk_loaded)
    else $error("break request did not load a break frame");
  txen_flush_a: assert property (!tx_en |=> s_q.txn == 3'h0 && s_q.txs == TX_IDLE)
    else $error("disabled transmitter kept queued data");
  tx_full_refuse_a: assert property (tx_full && tx_en && reg_wr && reg_addr == TXD_IDX
                                     && !tx_pop |=> s_q.txn == FIFO_DEPTH && stat_word[ST_TXBF])
    else $error("write accepted into a full transmit queue");
  tx_done_irq_a: assert property (tx_done && tx_mode == TXI_DONE && s_q.txn == 3'h0
                                  && !tx_push |=> tx_irq && stat_word[ST_TX_ALL_EMPTY_FLAG])
    else $error("completion interrupt missing");
  tx_bit_width_a: assert property (s_q.txs == TX_SHIFT |-> s_q.tsc < spb)
    else $error("transmit sample count beyond samples per bit");
  rx_idle_hold_a: assert property (s_q.rxs == RX_IDLE && rxb |=> stat_word[ST_RX_IDLE_FLAG])
    else $error("receiver left idle on an idle line");
  addr_drop_a: assert property (rx_done && s_q.stat[ST_ADDR_DETECT_EN] && fmt == FMT_9N
                                && !rx_full[8] |-> !rx_push)
    else $error("non-address character stored in address mode");
  ovr_set_a: assert property (rx_done && rx_keep && s_q.rxn == FIFO_DEPTH
                              |=> s_q.stat[ST_OVERRUN_FLAG] && s_q.rxn != 3'h0)
    else $error("overflow did not set overrun");
  rx_count_a: assert property (rx_push && !rx_pop && !rx_flush
                               |=> s_q.rxn == $past(s_q.rxn) + 3'h1 && stat_word[ST_RXDA])
    else $error("stored character not counted");

endmodule

`default_nettype wire

/* File: core/serial_port_pkg.sv */
/*
  Shared constants and types for the asynchronous serial port: register
  indices, field positions, reset values, frame encodings and state types.
  Assumes a single 100 MHz clock domain and a word-indexed register port.
*/
package serial_port_pkg;

  // ---------------------------------------------------------------
  // register indices (word addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_IDX = 3'h0;
  localparam logic [2:0] STAT_IDX = 3'h1;
  localparam logic [2:0] TXD_IDX = 3'h2;
  localparam logic [2:0] RXD_IDX = 3'h3;
  localparam logic [2:0] BAUD_IDX = 3'h4;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_INFRARED_CODING_EN = 12;
  localparam int MODE_RXINV = 4;
  localparam int MODE_HIGH_SPEED_BAUD = 3;
  localparam int MODE_FMT = 1;
  localparam int MODE_STOP_BITS_SEL = 0;
  localparam int ST_TXIS1 = 15;
  localparam int ST_TXINV = 14;
  localparam int ST_TXIS0 = 13;
  localparam int ST_BRK = 11;
  localparam int ST_TXEN = 10;
  localparam int ST_TXBF = 9;
  localparam int ST_TX_ALL_EMPTY_FLAG = 8;
  localparam int ST_RXIS = 6;
  localparam int ST_ADDR_DETECT_EN = 5;
  localparam int ST_RX_IDLE_FLAG = 4;
  localparam int ST_PARITY_ERR_FLAG = 3;
  localparam int ST_FRAMING_ERR_FLAG = 2;
  localparam int ST_OVERRUN_FLAG = 1;
  localparam int ST_RXDA = 0;

  // ---------------------------------------------------------------
  // reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WR_MASK = 16'h101f;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] STAT_WR_MASK = 16'hece0;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // frame encodings and counts
  // ---------------------------------------------------------------
  localparam logic [4:0] SPB_HIGH = 5'h04;
  localparam logic [4:0] SPB_STD = 5'h10;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [1:0] FMT_9N = 2'h3;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] TXI_EACH = 2'h0;
  localparam logic [1:0] TXI_DONE = 2'h1;
  localparam logic [1:0] TXI_EMPTY = 2'h2;
  localparam logic [1:0] RXI_FULL = 2'h3;
  localparam logic [1:0] RXI_3Q = 2'h2;
  localparam logic [13:0] BREAK_FRAME = 14'h2000;
  localparam logic [3:0] BREAK_LEN = 4'he;
  localparam logic [4:0] IR_PULSE = 5'h03;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

endpackage

/* File: tb/remote_node.sv */
/*
  Remote serial node on the far side of the port: sends frames into the
  receive pin and decodes frames seen on the transmit pin.
  Assumes one clock shared with the port and plain (non-infrared) coding.
*/
`timescale 1ns/10ps
`default_nettype none
module remote_node (
  input wire logic sys_clk,
  input wire logic tx_line,
  output wire logic rx_line
);
  logic lvl;
  logic inv;

  // idle level follows the receive polarity, as the pull resistor would
  assign rx_line = lvl ^ inv;

  initial
  begin
    lvl = 1'b1;
    inv = 1'b0;
  end

  // ----------------------------------------
  // frame toward the port; pb below zero means no parity bit
  // ----------------------------------------
  task automatic send(input logic [8:0] d, input int nd, input int pb, input logic stp,
    input int spb);
    logic [12:0] f;
    int n;
    begin
      f = '0;
      for (int i = 0; i < nd; i++)
        f[1 + i] = d[i];
      n = nd + 1;
      if (pb >= 0)
      begin
        f[n] = pb[0];
        n++;
      end
      f[n] = stp;
      @(posedge sys_clk);
      for (int i = 0; i <= n; i++)
      begin
        lvl <= f[i];
        repeat (spb) @(posedge sys_clk);
      end
      lvl <= 1'b1;
    end
  endtask

  // ----------------------------------------
  // frame from the port, sampled mid-bit; gap counts idle clocks after it
  // ----------------------------------------
  task automatic get(input int nd, input int spb, output logic [8:0] d, output int gap);
    int w;
    begin
      d = '0;
      gap = 0;
      w = 0;
      while (tx_line !== 1'b0 && w < 3000)
      begin
        @(negedge sys_clk);
        w++;
      end
      if (w >= 3000)
        gap = -1;
      else
      begin
        repeat (spb / 2) @(negedge sys_clk);
        for (int i = 0; i < nd; i++)
        begin
          repeat (spb) @(negedge sys_clk);
          d[i] = tx_line;
        end
        w = 0;
        while (w < 200 && !(gap > 0 && tx_line === 1'b0))
        begin
          @(negedge sys_clk);
          w++;
          if (tx_line === 1'b1)
            gap++;
        end
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking bench for the serial port: register tasks, a remote node
  on the serial pins, and directed transmit and receive sequences.
  Assumes baud divisor 0, so one bit lasts 16 or 4 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import serial_port_pkg::*;

  logic sys_clk;
  logic rst_n;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  wire logic rx_line;
  logic tx_line;
  logic tx_line_oe;
  logic tx_irq;
  logic rx_irq;
  int n_errors;
  int n_checks;
  int n_tx_irq;
  int n_rx_irq;
  int base;
  int g;
  int w;
  int lows;

  serial_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_line(rx_line), .tx_line(tx_line), .tx_line_oe(tx_line_oe), .tx_irq(tx_irq),
    .rx_irq(rx_irq));

  remote_node remote (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(rx_line));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (tx_irq === 1'b1)
      n_tx_irq <= n_tx_irq + 1;
    if (rx_irq === 1'b1)
      n_rx_irq <= n_rx_irq + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out;
    begin
      if (n_errors == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task automatic compare(input logic [15:0] got, input logic [15:0] want, input string what);
    begin
      n_checks++;
      if (got !== want)
      begin
        n_errors++;
        $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
    end
  endtask

  task automatic range_chk(input int got, input int lo, input int hi, input string what);
    begin
      n_checks++;
      if (got < lo || got > hi)
      begin
        n_errors++;
        $display("unexpected at %0t: %s is %0d", $time, what, got);
      end
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [15:0] m, input logic [15:0] want);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      compare(reg_rdata & m, want, "register read");
    end
  endtask

  task automatic rx_frame(input int nd, input int spb, input logic [8:0] want);
    logic [8:0] d;
    begin
      remote.get(nd, spb, d, g);
      if (g < 0)
      begin
        n_errors++;
        $display("unexpected at %0t: no frame on the transmit line", $time);
        close_out();
      end
      compare({7'h00, d}, {7'h00, want}, "transmitted frame");
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_errors = 0;
    n_checks = 0;
    n_tx_irq = 0;
    n_rx_irq = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_reg(STAT_IDX, 16'hffff, 16'h0110);
    chk_reg(MODE_IDX, 16'hffff, 16'h0000);
    chk_reg(3'h5, 16'hffff, 16'h0000);
    wr(BAUD_IDX, 16'h0000);
    wr(STAT_IDX, 16'h0400);
    cyc(2);
    compare({15'h0, tx_line_oe}, 16'h0001, "pin drive");
    base = n_tx_irq;
    for (int f = 0; f < 4; f++)
    begin
      wr(MODE_IDX, 16'(f << MODE_FMT));
      fork
        wr(TXD_IDX, 16'h01a5);
        rx_frame((f == 0) ? 8 : 9, 16, (f >= 2) ? 9'h1a5 : 9'h0a5);
      join
    end
    compare(16'(n_tx_irq - base), 16'h0004, "tx events on load");
    // two stop bits, full queue, dropped sixth write
    wr(MODE_IDX, 16'h0001);
    wr(STAT_IDX, 16'h8400);
    base = n_tx_irq;
    fork
      begin
        for (int i = 0; i < 5; i++)
          wr(TXD_IDX, 16'h0050 + 16'(i));
        chk_reg(STAT_IDX, 16'h0300, 16'h0200);
        wr(TXD_IDX, 16'h0077);
      end
      for (int i = 0; i < 5; i++)
      begin
        rx_frame(8, 16, 9'h050 + 9'(i));
        if (i == 0)
          range_chk(g, 31, 35, "stop span");
      end
    join
    range_chk(g, 150, 200, "idle after queue");
    compare(16'(n_tx_irq - base), 16'h0002, "tx events on empty");
    chk_reg(STAT_IDX, 16'h0300, 16'h0100);
    // abort in mid-frame
    wr(MODE_IDX, 16'h0000);
    wr(STAT_IDX, 16'h0400);
    for (int i = 0; i < 3; i++)
      wr(TXD_IDX, 16'h0011);
    cyc(40);
    wr(STAT_IDX, 16'h0000);
    cyc(2);
    compare({15'h0, tx_line_oe}, 16'h0000, "pin released");
    chk_reg(STAT_IDX, 16'h0300, 16'h0100);
    wr(STAT_IDX, 16'h0400);
    lows = 0;
    repeat (300)
    begin
      @(negedge sys_clk);
      if (tx_line !== 1'b1)
        lows++;
    end
    compare(16'(lows), 16'h0000, "frame after abort");
    // transmit idle levels; infrared only in sixteen-sample mode
    wr(STAT_IDX, 16'h4400);
    cyc(3);
    compare({15'h0, tx_line}, 16'h0000, "inverted idle");
    wr(MODE_IDX, 16'h1000);
    cyc(3);
    compare({15'h0, tx_line}, 16'h0001, "infrared idle");
    wr(MODE_IDX, 16'h0000);
    // break, then a queued character, with the reserved tx event mode
    wr(STAT_IDX, 16'hac00);
    wr(TXD_IDX, 16'h0055);
    base = n_tx_irq;
    w = 0;
    while (tx_line !== 1'b0 && w < 100)
    begin
      @(negedge sys_clk);
      w++;
    end
    if (w >= 100)
    begin
      n_errors++;
      close_out();
    end
    lows = 0;
    while (tx_line === 1'b0 && lows < 400)
    begin
      @(negedge sys_clk);
      lows++;
    end
    range_chk(lows, 206, 209, "break low span");
    // the queued character must finish before the mode changes
    cyc(200);
    chk_reg(STAT_IDX, 16'h0800, 16'h0000);
    compare(16'(n_tx_irq - base), 16'h0000, "reserved tx mode");
    // four samples per bit, event on completion
    wr(MODE_IDX, 16'h0008);
    wr(STAT_IDX, 16'h2400);
    base = n_tx_irq;
    fork
      wr(TXD_IDX, 16'h0033);
      rx_frame(8, 4, 9'h033);
    join
    compare(16'(n_tx_irq - base), 16'h0001, "tx event on completion");
    // receive path
    wr(MODE_IDX, 16'h0000);
    wr(STAT_IDX, 16'h0400);
    base = n_rx_irq;
    chk_reg(STAT_IDX, 16'h0011, 16'h0010);
    fork
      remote.send(9'h05a, 8, -1, 1'b1, 16);
      begin
        cyc(60);
        chk_reg(STAT_IDX, 16'h0010, 16'h0000);
      end
    join
    cyc(20);
    chk_reg(STAT_IDX, 16'h001f, 16'h0011);
    chk_reg(RXD_IDX, 16'hffff, 16'h005a);
    chk_reg(STAT_IDX, 16'h0001, 16'h0000);
    compare(16'(n_rx_irq - base), 16'h0001, "rx event each");
    wr(MODE_IDX, 16'h0002);
    remote.send(9'h05a, 8, 1, 1'b1, 16);
    remote.send(9'h03c, 8, 0, 1'b1, 16);
    cyc(20);
    chk_reg(STAT_IDX, 16'h000d, 16'h0009);
    chk_reg(RXD_IDX, 16'hffff, 16'h005a);
    chk_reg(STAT_IDX, 16'h000d, 16'h0001);
    chk_reg(RXD_IDX, 16'hffff, 16'h003c);
    wr(MODE_IDX, 16'h0000);
    remote.send(9'h0c3, 8, -1, 1'b0, 16);
    cyc(20);
    chk_reg(STAT_IDX, 16'h000d, 16'h0005);
    cyc(200);
    chk_reg(RXD_IDX, 16'h0000, 16'h0000);
    chk_reg(RXD_IDX, 16'h0000, 16'h0000);
    chk_reg(STAT_IDX, 16'h0005, 16'h0000);
    // thresholds and overrun
    wr(STAT_IDX, 16'h0480);
    base = n_rx_irq;
    for (int i = 0; i < 3; i++)
      remote.send(9'h010 + 9'(i), 8, -1, 1'b1, 16);
    cyc(20);
    compare(16'(n_rx_irq - base), 16'h0001, "rx event at three");
    wr(STAT_IDX, 16'h04c0);
    remote.send(9'h013, 8, -1, 1'b1, 16);
    cyc(20);
    compare(16'(n_rx_irq - base), 16'h0002, "rx event at four");
    remote.send(9'h014, 8, -1, 1'b1, 16);
    cyc(20);
    chk_reg(STAT_IDX, 16'h0003, 16'h0003);
    wr(STAT_IDX, 16'h04c0);
    chk_reg(STAT_IDX, 16'h0003, 16'h0000);
    // address detect, nine-bit only
    wr(MODE_IDX, 16'h0006);
    wr(STAT_IDX, 16'h0420);
    remote.send(9'h0a5, 9, -1, 1'b1, 16);
    cyc(20);
    chk_reg(STAT_IDX, 16'h0001, 16'h0000);
    remote.send(9'h1a5, 9, -1, 1'b1, 16);
    cyc(20);
    chk_reg(RXD_IDX, 16'hffff, 16'h01a5);
    wr(MODE_IDX, 16'h0000);
    remote.send(9'h033, 8, -1, 1'b1, 16);
    cyc(20);
    chk_reg(RXD_IDX, 16'hffff, 16'h0033);
    // inverted receive polarity; line and setting flip together
    fork
      wr(MODE_IDX, 16'h0010);
      begin
        @(posedge sys_clk);
        remote.inv <= 1'b1;
      end
    join
    cyc(40);
    remote.send(9'h096, 8, -1, 1'b1, 16);
    cyc(20);
    chk_reg(RXD_IDX, 16'hffff, 16'h0096);
    close_out();
  end
endmodule
`default_nettype wire
